// File: rtl/fpb_defs.vh
`ifndef FPB_DEFS_VH
`define FPB_DEFS_VH
// Register byte offsets
`define FPB_REG_CMD 8'h00
`define FPB_REG_ADDR 8'h04
`define FPB_REG_DATA 8'h08
`define FPB_REG_STAT 8'h0C
`define FPB_REG_CRC 8'h10
`define FPB_REG_BOOT 8'h14
`define FPB_REG_SEC 8'h18
`define FPB_REG_CFG 8'h1C
`define FPB_REG_START 8'h20
`define FPB_REG_ENTRY 8'h24
// Command codes
`define FPB_CMD_LOAD 4'h1
`define FPB_CMD_PROG 4'h2
`define FPB_CMD_ERPG 4'h3
`define FPB_CMD_ERSEC 4'h4
`define FPB_CMD_ERCHIP 4'h5
`define FPB_CMD_CRCSEC 4'h6
`define FPB_CMD_CRCALL 4'h7
`define FPB_CMD_WRBOOT 4'h8
`define FPB_CMD_WRSEC 4'h9
`define FPB_CMD_WRCFG 4'hA
`define FPB_CMD_CLRPB 4'hB
// Status bit positions
`define FPB_ST_BUSY 0
`define FPB_ST_DONE 1
`define FPB_ST_PROT 2
`define FPB_ST_BAD 3
// Reset values and fixed addresses
`define FPB_BOOTVEC_RST 8'h1E
`define FPB_BOOTSTAT_RST 1'b1
`define FPB_CFG_RST 8'h00
`define FPB_ENTRY_ADDR 16'hFF00
`define FPB_LOADER_BASE 13'h1E00
`define FPB_CRC_POLY 32'h04C11DB7
`define FPB_CRC_INIT 32'hFFFFFFFF
// Operation time in microseconds, cycles at 125 MHz
`define FPB_OP_US 2000
`define FPB_CLK_MHZ 125
`define FPB_OP_CYC (`FPB_OP_US * `FPB_CLK_MHZ)
`endif

// File: rtl/fpb_crc32.v
`timescale 1ns/10ps
// One-byte step of the CRC-32 used for read-back checks
module fpb_crc32 (
    input wire [31:0] crc_in,
    input wire [7:0] data_in,
    output wire [31:0] crc_out
);
`include "fpb_defs.vh"
    reg [31:0] c;
    integer i;
    // Bitwise MSB-first shift, unrolled by the loop
    always @* begin
        c = crc_in;
        for (i = 7; i >= 0; i = i - 1) begin
            if (c[31] ^ data_in[i]) begin
                c = {c[30:0], 1'b0} ^ `FPB_CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
    end
    assign crc_out = c;
endmodule // fpb_crc32

// File: rtl/fpb_ctrl.v
`timescale 1ns/10ps
// Functional notes
// RL1 - Eight 1 kB sectors, 64-byte pages
// RL2 - 64-byte buffer programs 1 to 64 bytes
// RL3 - Sector, page and chip erase supported
// RL4 - Every operation finishes within 2 ms
// RL5 - No read-back; CRC over sector or all
// RL6 - Boot status zero starts at 0000H
// RL7 - Nonzero status starts at vector:00H
// RL8 - Boot vector leaves factory as 1EH
// RL9 - Forced loader mode also uses vector
// RL10 - Routines entered at single address FF00H
// RL11 - Config byte, status, vector reprogrammable
// RL12 - Top 512 bytes hold serial loader
// RL13 - Keep loader: page-erase 1C00H to 1DFFH
// RL14 - Clear boot status after programming
// RL15 - Per-sector protection, alterable by routines
// RL16 - New requests ignored while busy
`include "fpb_defs.vh"
module fpb_ctrl #(
    parameter OP_CYCLES = `FPB_OP_CYC,
    parameter SECTORS = 8,
    parameter PAGE_BYTES = 64
) (
    input wire core_clk_in,
    input wire resetn_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire serial_loader_mode_in,
    output reg [15:0] start_addr_out,
    output wire busy_out
);
    localparam MEM_BYTES = SECTORS * 1024;
    localparam S_IDLE = 3'd0;
    localparam S_PROG = 3'd1;
    localparam S_ERASE = 3'd2;
    localparam S_CRC = 3'd3;
    localparam S_WAIT = 3'd4;
    localparam S_BOOT = 3'd5;

    // Flash array, page buffer and special bytes
    reg [7:0] flash_mem [0:MEM_BYTES-1]; // [RL1]
    reg [7:0] page_buf [0:PAGE_BYTES-1]; // [RL2]
    reg [PAGE_BYTES-1:0] pb_valid_q;
    reg [7:0] boot_vec_q;
    reg boot_stat_q;
    reg [7:0] power_up_config_byte_q;
    reg [SECTORS-1:0] sec_prot_q;
    reg [2:0] state_q;
    reg [3:0] op_q;
    reg [12:0] addr_q;
    reg [12:0] ptr_q;
    reg [12:0] end_q;
    reg [31:0] crc_q;
    reg [31:0] wait_q;
    reg done_q;
    reg prot_q;
    reg bad_q;
    reg [7:0] data_q;
    reg ack_q;
    reg ldr_s1_q;
    reg ldr_s2_q;
    wire [31:0] crc_next;
    wire req;
    wire take;
    integer k;

    // Sector index of an address
    function [2:0] sec_of;
        input [12:0] a;
        begin
            sec_of = a[12:10];
        end
    endfunction

    // Any listed protected sector in a range blocks a sector erase
    function range_prot;
        input [12:0] lo;
        input [12:0] hi;
        input [SECTORS-1:0] prot;
        integer s;
        begin
            range_prot = 1'b0;
            for (s = 0; s < SECTORS; s = s + 1) begin
                if (prot[s] && s >= sec_of(lo) && s <= sec_of(hi)) begin
                    range_prot = 1'b1;
                end
            end
        end
    endfunction

    fpb_crc32 u_crc (
        .crc_in(crc_q),
        .data_in(flash_mem[ptr_q]),
        .crc_out(crc_next)
    );

    // One wait cycle: read data loads on the first edge, so it stands when waitrequest
    // drops; writes land only on the edge where waitrequest is low
    assign req = (avs_read_in | avs_write_in) & ~ack_q;
    assign take = (avs_read_in | avs_write_in) & ack_q;
    assign avs_waitrequest_out = req;
    assign busy_out = (state_q != S_IDLE) && (state_q != S_BOOT);

    // Strap synchroniser kept out of reset, so the strap is settled at release [RL9]
    always @(posedge core_clk_in) begin
        ldr_s1_q <= serial_loader_mode_in;
        ldr_s2_q <= ldr_s1_q;
    end

    // Power-up contents: erased array and factory boot, config and security bytes.
    // These are flash elements, so no reset touches them afterwards [RL6]
    initial begin
        for (k = 0; k < MEM_BYTES; k = k + 1) begin
            flash_mem[k] = 8'hFF; // Top 512 bytes reserved for loader [RL12]
        end
        boot_vec_q = `FPB_BOOTVEC_RST; // [RL8]
        boot_stat_q = `FPB_BOOTSTAT_RST;
        power_up_config_byte_q = `FPB_CFG_RST;
        sec_prot_q = {SECTORS{1'b0}};
    end

    // Bus response and readback
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_q <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req && avs_read_in) begin
                case (avs_address_in)
                    `FPB_REG_ADDR: avs_readdata_out <= {19'h00000, addr_q};
                    `FPB_REG_DATA: avs_readdata_out <= {24'h000000, data_q};
                    `FPB_REG_STAT: avs_readdata_out <= {28'h0000000, bad_q, prot_q,
                        done_q, busy_out};
                    `FPB_REG_CRC: avs_readdata_out <= crc_q; // [RL5]
                    `FPB_REG_BOOT: avs_readdata_out <= {23'h000000, boot_stat_q,
                        boot_vec_q};
                    `FPB_REG_SEC: avs_readdata_out <= {{(32-SECTORS){1'b0}}, sec_prot_q};
                    `FPB_REG_CFG: avs_readdata_out <= {24'h000000, power_up_config_byte_q};
                    `FPB_REG_START: avs_readdata_out <= {16'h0000, start_addr_out};
                    `FPB_REG_ENTRY: avs_readdata_out <= {16'h0000, `FPB_ENTRY_ADDR}; // [RL10]
                    default: avs_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Sequencer: command decode, timed operations, boot selection
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= S_BOOT;
            op_q <= 4'h0;
            addr_q <= 13'h0000;
            ptr_q <= 13'h0000;
            end_q <= 13'h0000;
            crc_q <= 32'h00000000;
            wait_q <= 32'h00000000;
            done_q <= 1'b0;
            prot_q <= 1'b0;
            bad_q <= 1'b0;
            data_q <= 8'h00;
            pb_valid_q <= {PAGE_BYTES{1'b0}};
            start_addr_out <= 16'h0000;
        end else begin
            if (take && avs_write_in && avs_address_in == `FPB_REG_ADDR && !busy_out) begin
                addr_q <= avs_writedata_in[12:0];
            end
            if (take && avs_write_in && avs_address_in == `FPB_REG_DATA) begin
                data_q <= avs_writedata_in[7:0];
            end
            case (state_q)
                S_BOOT: begin
                    // Strap sampled after release through the synchroniser
                    if (boot_stat_q || ldr_s2_q) begin
                        start_addr_out <= {boot_vec_q, 8'h00}; // [RL7] [RL9]
                    end else begin
                        start_addr_out <= 16'h0000; // [RL6]
                    end
                    state_q <= S_IDLE;
                end
                S_IDLE: begin
                    if (take && avs_write_in && avs_address_in == `FPB_REG_CMD) begin // [RL16]
                        op_q <= avs_writedata_in[3:0];
                        done_q <= 1'b0;
                        prot_q <= 1'b0;
                        bad_q <= 1'b0;
                        wait_q <= 32'h00000000;
                        case (avs_writedata_in[3:0])
                            `FPB_CMD_LOAD: begin
                                page_buf[addr_q[5:0]] <= avs_writedata_in[15:8];
                                pb_valid_q[addr_q[5:0]] <= 1'b1;
                                addr_q <= addr_q + 13'h0001;
                                done_q <= 1'b1;
                            end
                            `FPB_CMD_CLRPB: begin
                                pb_valid_q <= {PAGE_BYTES{1'b0}};
                                done_q <= 1'b1;
                            end
                            `FPB_CMD_PROG: begin
                                // Page aligned; only loaded bytes are written [RL2]
                                ptr_q <= {addr_q[12:6], 6'h00};
                                end_q <= {addr_q[12:6], 6'h3F};
                                if (sec_prot_q[sec_of(addr_q)]) begin
                                    prot_q <= 1'b1;
                                    done_q <= 1'b1;
                                end else begin
                                    state_q <= S_PROG;
                                end
                            end
                            `FPB_CMD_ERPG, `FPB_CMD_ERSEC, `FPB_CMD_ERCHIP: begin
                                if (avs_writedata_in[3:0] == `FPB_CMD_ERPG) begin
                                    ptr_q <= {addr_q[12:6], 6'h00}; // [RL3]
                                    end_q <= {addr_q[12:6], 6'h3F};
                                end else if (avs_writedata_in[3:0] == `FPB_CMD_ERSEC) begin
                                    ptr_q <= {addr_q[12:10], 10'h000}; // [RL3]
                                    end_q <= {addr_q[12:10], 10'h3FF};
                                end else begin
                                    ptr_q <= 13'h0000; // [RL3]
                                    end_q <= 13'h1FFF;
                                end
                                // Chip erase also clears protection; others honour it
                                if (avs_writedata_in[3:0] == `FPB_CMD_ERCHIP) begin
                                    sec_prot_q <= {SECTORS{1'b0}};
                                    state_q <= S_ERASE;
                                end else if (avs_writedata_in[3:0] == `FPB_CMD_ERPG
                                    && sec_prot_q[sec_of(addr_q)]) begin
                                    prot_q <= 1'b1; // [RL15]
                                    done_q <= 1'b1;
                                end else if (avs_writedata_in[3:0] == `FPB_CMD_ERSEC
                                    && range_prot({addr_q[12:10], 10'h000},
                                    {addr_q[12:10], 10'h3FF}, sec_prot_q)) begin
                                    prot_q <= 1'b1; // [RL15]
                                    done_q <= 1'b1;
                                end else begin
                                    state_q <= S_ERASE;
                                end
                            end
                            `FPB_CMD_CRCSEC, `FPB_CMD_CRCALL: begin
                                crc_q <= `FPB_CRC_INIT;
                                if (avs_writedata_in[3:0] == `FPB_CMD_CRCSEC) begin
                                    ptr_q <= {addr_q[12:10], 10'h000}; // [RL5]
                                    end_q <= {addr_q[12:10], 10'h3FF};
                                end else begin
                                    ptr_q <= 13'h0000; // [RL5]
                                    end_q <= 13'h1FFF;
                                end
                                state_q <= S_CRC;
                            end
                            `FPB_CMD_WRBOOT: begin
                                boot_vec_q <= data_q; // [RL11]
                                boot_stat_q <= avs_writedata_in[8];
                                state_q <= S_WAIT;
                            end
                            `FPB_CMD_WRSEC: begin
                                sec_prot_q <= data_q[SECTORS-1:0]; // [RL15]
                                state_q <= S_WAIT;
                            end
                            `FPB_CMD_WRCFG: begin
                                power_up_config_byte_q <= data_q; // [RL11]
                                state_q <= S_WAIT;
                            end
                            default: begin
                                bad_q <= 1'b1;
                                done_q <= 1'b1;
                            end
                        endcase
                    end
                end
                S_PROG: begin
                    // Array written one byte a cycle, then pulse time pads to 2 ms
                    if (pb_valid_q[ptr_q[5:0]]) begin
                        flash_mem[ptr_q] <= page_buf[ptr_q[5:0]];
                    end
                    wait_q <= wait_q + 32'h00000001;
                    if (ptr_q == end_q) begin
                        pb_valid_q <= {PAGE_BYTES{1'b0}};
                        state_q <= S_WAIT;
                    end else begin
                        ptr_q <= ptr_q + 13'h0001;
                    end
                end
                S_ERASE: begin
                    flash_mem[ptr_q] <= 8'hFF;
                    wait_q <= wait_q + 32'h00000001;
                    if (ptr_q == end_q) begin
                        state_q <= S_WAIT;
                    end else begin
                        ptr_q <= ptr_q + 13'h0001;
                    end
                end
                S_CRC: begin
                    crc_q <= crc_next;
                    if (ptr_q == end_q) begin
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        ptr_q <= ptr_q + 13'h0001;
                    end
                end
                S_WAIT: begin
                    // Internal pulse timer; pads the total to OP_CYCLES unless the array walk already took longer [RL4]
                    if (wait_q >= OP_CYCLES - 1) begin
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        wait_q <= wait_q + 32'h00000001;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
    // Commands written while busy fall outside S_IDLE and are dropped [RL16]
endmodule // fpb_ctrl

// File: tb/fpb_ctrl_monitor.sv
`timescale 1ns/10ps
`include "fpb_defs.vh"
// Port-level checks on the flash controller
module fpb_ctrl_monitor #(
    parameter OP_CYCLES = 200
) (
    input wire core_clk_in,
    input wire resetn_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire serial_loader_mode_in,
    input wire [15:0] start_addr_out,
    input wire busy_out
);
    // Chip erase and full CRC walk 8192 bytes even when OP_CYCLES is shortened
    localparam integer LIMIT = (OP_CYCLES > 8192) ? OP_CYCLES + 16 : 8192 + 64;
    wire req;
    reg [31:0] busy_cnt_q;
    reg [1:0] rel_cnt_q;
    assign req = avs_read_in | avs_write_in;
    // Busy span length and edges since reset release
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_cnt_q <= 32'h0;
            rel_cnt_q <= 2'h0;
        end else begin
            busy_cnt_q <= busy_out ? busy_cnt_q + 32'h1 : 32'h0;
            if (rel_cnt_q != 2'h3) begin
                rel_cnt_q <= rel_cnt_q + 2'h1;
            end
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    property p_wait_first;
        $rose(req) |-> avs_waitrequest_out;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait on new request");
    property p_wait_one;
        req && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
    property p_rd_hold;
        !$stable(avs_readdata_out) |-> $past(avs_read_in);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_entry;
        avs_read_in && avs_waitrequest_out && avs_address_in == `FPB_REG_ENTRY
            |=> avs_readdata_out[15:0] == `FPB_ENTRY_ADDR;
    endproperty
    a_entry: assert property (p_entry) else $error("entry address wrong");
    property p_unmapped;
        avs_read_in && avs_waitrequest_out && avs_address_in > 8'h24 |=> avs_readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_busy_cause;
        $rose(busy_out) |-> $past(avs_write_in && avs_address_in == `FPB_REG_CMD);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
    property p_busy_bound;
        busy_cnt_q <= LIMIT;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("operation overran");
    property p_start_low;
        start_addr_out[7:0] == 8'h00;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start low byte not zero");
    property p_start_hold;
        rel_cnt_q >= 2'h2 |-> $stable(start_addr_out);
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start moved after boot");
endmodule // fpb_ctrl_monitor
bind fpb_ctrl fpb_ctrl_monitor #(.OP_CYCLES(OP_CYCLES)) u_mon (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .serial_loader_mode_in(serial_loader_mode_in),
    .start_addr_out(start_addr_out),
    .busy_out(busy_out)
);

// File: tb/fpb_cpu_model.sv
`timescale 1ns/10ps
// CPU stand-in that calls the flash routines over the register bus
module fpb_cpu_model (
    input wire clk_in,
    input wire [31:0] rdata_in,
    input wire wait_in,
    output reg [7:0] addr_out,
    output reg rd_out,
    output reg wr_out,
    output reg [31:0] wdata_out,
    output reg hang_out
);
    // Idle bus at time zero
    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        hang_out = 1'b0;
    end
    // Request raised after an edge and held until waitrequest is seen low at a
    // rising edge; read data is taken at that same edge, then the strobes drop
    task xfer(input rd, input [7:0] a, input [31:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge clk_in);
            addr_out <= a;
            wdata_out <= d;
            rd_out <= rd;
            wr_out <= !rd;
            n = 0;
            do begin
                @(posedge clk_in);
                n = n + 1;
            end while (wait_in !== 1'b0 && n < 64);
            hang_out <= (n >= 64);
            q = rdata_in;
            rd_out <= 1'b0;
            wr_out <= 1'b0;
        end
    endtask
endmodule // fpb_cpu_model

// File: tb/flash_program_boot_control_tb.sv
`timescale 1ns/10ps
`include "fpb_defs.vh"
module flash_program_boot_control_tb;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg strap = 1'b0;
    wire [7:0] addr;
    wire rd, wr, wt, busy, hang;
    wire [31:0] wdata, rdata;
    wire [15:0] start;
    integer err_count = 0;
    integer total_checks = 0;
    integer i;
    reg [31:0] q, crc_e, crc_a;
    // 125 MHz core clock
    always #4 clk = ~clk;
    // Op time shortened so the run stays short
    fpb_ctrl #(.OP_CYCLES(200)) dut (.core_clk_in(clk), .resetn_in(rstn),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
        .serial_loader_mode_in(strap), .start_addr_out(start), .busy_out(busy));
    fpb_cpu_model m (.clk_in(clk), .rdata_in(rdata), .wait_in(wt), .addr_out(addr),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdata), .hang_out(hang));
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    // A stuck bus cycle ends the run
    always @(posedge hang) begin
        err_count = err_count + 1;
        wrap_up;
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr_r(input [7:0] a, input [31:0] d);
        m.xfer(1'b0, a, d, q);
    endtask
    task rd_r(input [7:0] a);
        m.xfer(1'b1, a, 32'h0, q);
    endtask
    // Issue a command, then poll busy under a bound
    task cmd(input [31:0] c);
        integer n;
        begin
            wr_r(`FPB_REG_CMD, c);
            n = 0;
            q = 32'h1;
            while (q[0] !== 1'b0 && n < 4000) begin
                rd_r(`FPB_REG_STAT);
                n = n + 1;
            end
            if (q[0] !== 1'b0) begin
                err_count = err_count + 1;
                wrap_up;
            end
        end
    endtask
    task crc_sec(input [31:0] a);
        begin
            wr_r(`FPB_REG_ADDR, a);
            cmd(`FPB_CMD_CRCSEC);
            rd_r(`FPB_REG_CRC);
        end
    endtask
    task load(input [7:0] b);
        wr_r(`FPB_REG_CMD, {16'h0, b, 4'h0, `FPB_CMD_LOAD});
    endtask
    // Reference CRC-32, MSB first, over an erased span with optional test patterns
    function [31:0] ref_crc(input integer len, input p64, input p1);
        integer j, k;
        reg [7:0] b;
        begin
            ref_crc = `FPB_CRC_INIT;
            for (j = 0; j < len; j = j + 1) begin
                b = (p64 && j >= 64 && j < 128) ? ({2'b00, j[5:0]} ^ 8'hA5) : 8'hFF;
                if (p1 && j == 451) begin
                    b = 8'h3C;
                end
                for (k = 7; k >= 0; k = k - 1) begin
                    if (ref_crc[31] ^ b[k]) begin
                        ref_crc = {ref_crc[30:0], 1'b0} ^ `FPB_CRC_POLY;
                    end else begin
                        ref_crc = {ref_crc[30:0], 1'b0};
                    end
                end
            end
        end
    endfunction
    // Strap is set as reset is asserted so it is stable well ahead of release
    task reboot(input s);
        begin
            @(posedge clk);
            rstn <= 1'b0;
            strap <= s;
            repeat (10) @(posedge clk);
            rstn <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    // Main sequence
    initial begin
        reboot(1'b0);
        rd_r(`FPB_REG_BOOT);
        chk("boot", 32'h11E, q);
        chk("start", 32'h1E00, {16'h0, start});
        rd_r(`FPB_REG_ENTRY);
        chk("entry", 32'hFF00, q);
        rd_r(8'h3C);
        chk("unmapped", 32'h0, q);
        $display("test factory_boot done");
        cmd(`FPB_CMD_ERCHIP);
        crc_sec(32'h1C00);
        crc_e = ref_crc(1024, 1'b0, 1'b0);
        chk("crc_erased", crc_e, q);
        cmd(`FPB_CMD_CRCALL);
        rd_r(`FPB_REG_CRC);
        crc_a = ref_crc(8192, 1'b0, 1'b0);
        chk("crc_all_erased", crc_a, q);
        // Full 64-byte page, then a page erase sent while busy must be dropped
        wr_r(`FPB_REG_ADDR, 32'h1C40);
        for (i = 0; i < 64; i = i + 1) load(i[7:0] ^ 8'hA5);
        wr_r(`FPB_REG_ADDR, 32'h1C40);
        wr_r(`FPB_REG_CMD, `FPB_CMD_PROG);
        rd_r(`FPB_REG_STAT);
        chk("busy_prog", 32'h3, {30'h0, busy, q[`FPB_ST_BUSY]});
        cmd(`FPB_CMD_ERPG);
        crc_sec(32'h1C00);
        chk("crc_prog64", ref_crc(1024, 1'b1, 1'b0), q);
        // Single byte in another page of the same sector
        cmd(`FPB_CMD_CLRPB);
        wr_r(`FPB_REG_ADDR, 32'h1DC3);
        load(8'h3C);
        wr_r(`FPB_REG_ADDR, 32'h1DC3);
        cmd(`FPB_CMD_PROG);
        crc_sec(32'h1C00);
        chk("crc_prog1", ref_crc(1024, 1'b1, 1'b1), q);
        // Loader kept: clear only the eight pages below it
        for (i = 0; i < 8; i = i + 1) begin
            wr_r(`FPB_REG_ADDR, 32'h1C00 + i * 64);
            cmd(`FPB_CMD_ERPG);
        end
        crc_sec(32'h1C00);
        chk("crc_pg_erase", crc_e, q);
        cmd(`FPB_CMD_CRCALL);
        rd_r(`FPB_REG_CRC);
        chk("crc_all", crc_a, q);
        // Sector erase in sector 1
        wr_r(`FPB_REG_ADDR, 32'h0410);
        load(8'h00);
        wr_r(`FPB_REG_ADDR, 32'h0410);
        cmd(`FPB_CMD_PROG);
        wr_r(`FPB_REG_ADDR, 32'h0400);
        cmd(`FPB_CMD_ERSEC);
        crc_sec(32'h0400);
        chk("crc_sec_erase", crc_e, q);
        $display("test program_erase done");
        wr_r(`FPB_REG_DATA, 32'h02);
        cmd(`FPB_CMD_WRSEC);
        rd_r(`FPB_REG_SEC);
        chk("sec", 32'h02, q);
        wr_r(`FPB_REG_ADDR, 32'h0400);
        cmd(`FPB_CMD_PROG);
        chk("prot", 32'h1, {31'h0, q[`FPB_ST_PROT]});
        cmd(`FPB_CMD_ERCHIP);
        rd_r(`FPB_REG_SEC);
        chk("sec_clr", 32'h0, q);
        wr_r(`FPB_REG_DATA, 32'h5C);
        cmd(`FPB_CMD_WRCFG);
        rd_r(`FPB_REG_CFG);
        chk("cfg", 32'h5C, q);
        $display("test security_config done");
        wr_r(`FPB_REG_DATA, 32'h12);
        cmd({23'h0, 1'b1, 4'h0, `FPB_CMD_WRBOOT});
        rd_r(`FPB_REG_BOOT);
        chk("boot_set", 32'h112, q);
        reboot(1'b0);
        chk("start_vec", 32'h1200, {16'h0, start});
        rd_r(`FPB_REG_START);
        chk("start_reg", 32'h1200, q);
        wr_r(`FPB_REG_DATA, 32'h12);
        cmd({23'h0, 1'b0, 4'h0, `FPB_CMD_WRBOOT});
        reboot(1'b0);
        chk("start_user", 32'h0, {16'h0, start});
        reboot(1'b1);
        chk("start_strap", 32'h1200, {16'h0, start});
        $display("test boot_select done");
        wrap_up;
    end
endmodule // flash_program_boot_control_tb
